// ### core/art_defines.vh
`ifndef ART_DEFINES_VH
`define ART_DEFINES_VH

// register addresses
`define ART_ADDR_CONTROL 8'h91
`define ART_ADDR_RELOAD_LOW 8'h92
`define ART_ADDR_RELOAD_HIGH 8'h93
`define ART_ADDR_COUNT_LOW 8'h94
`define ART_ADDR_COUNT_HIGH 8'h95

// control register fields
`define ART_BIT_HIGH_FLAG 7
`define ART_BIT_LOW_FLAG 6
`define ART_BIT_LOW_IRQ_EN 5
`define ART_BIT_CAPTURE_EN 4
`define ART_BIT_SPLIT 3
`define ART_BIT_RUN 2
`define ART_BIT_UNUSED 1
`define ART_BIT_EXT_SEL 0

// reset values
`define ART_RESET_CONTROL 8'h00
`define ART_RESET_BYTE 8'h00

// timing counts
`define ART_SYSTEM_CLOCK_DIV 4'hc
`define ART_EXT_DIV 4'h8
`define ART_SYNC_TICKS 2'h3

`endif

// ### core/art_edge_sync.v
`timescale 1ns/100ps
module art_edge_sync (
   input wire i_clk,
   input wire i_reset,
   input wire i_pin,
   output reg o_rise
);
   reg meta;
   reg stable;
   reg stable_prev;

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meta <= 1'b0;
         stable <= 1'b0;
         stable_prev <= 1'b0;
         o_rise <= 1'b0;
      end else begin
         meta <= i_pin;
         stable <= meta;
         stable_prev <= stable;
         o_rise <= stable & ~stable_prev;
      end
   end
endmodule // art_edge_sync

// ### core/art_tick_gen.v
`timescale 1ns/100ps
`include "art_defines.vh"
module art_tick_gen (
   input wire i_clk,
   input wire i_reset,
   input wire i_ext_rise,
   input wire i_suspend,
   input wire i_ext_sel,
   input wire i_high_system_clock,
   input wire i_low_system_clock,
   output wire o_tick_high,
   output wire o_tick_low,
   output wire o_ext_tick
);
   reg [3:0] div12;
   reg [3:0] div8;
   reg ext_tick_raw;
   reg ext_tick_sync;
   wire tick12;
   wire ext_tick;

   assign tick12 = (div12 == `ART_SYSTEM_CLOCK_DIV - 4'h1);

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         div12 <= 4'h0;
      end else if (tick12) begin
         div12 <= 4'h0;
      end else begin
         div12 <= div12 + 4'h1;
      end
   end

   // divide external edges by eight
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         div8 <= 4'h0;
         ext_tick_raw <= 1'b0;
         ext_tick_sync <= 1'b0;
      end else begin
         ext_tick_raw <= 1'b0;
         if (i_ext_rise) begin
            if (div8 == `ART_EXT_DIV - 4'h1) begin
               div8 <= 4'h0;
               ext_tick_raw <= 1'b1;
            end else begin
               div8 <= div8 + 4'h1;
            end
         end
         ext_tick_sync <= ext_tick_raw;
      end
   end

   // retimed outside suspend, direct in suspend
   assign ext_tick = i_suspend ? ext_tick_raw : ext_tick_sync;
   assign o_ext_tick = ext_tick;

   // per-byte clock source
   assign o_tick_high = i_suspend ? ext_tick :
      (i_high_system_clock ? 1'b1 : (i_ext_sel ? ext_tick : tick12));
   assign o_tick_low = i_suspend ? ext_tick :
      (i_low_system_clock ? 1'b1 : (i_ext_sel ? ext_tick : tick12));
endmodule // art_tick_gen

// ### core/art_timer.v
// Overview of operation
// - split bit 0: one 16-bit reload counter; 1: two 8-bit reload counters
// - 16-bit wrap from all ones loads reload value and sets high flag
// - 16-bit overflow requests interrupt when timer interrupt enable set
// - 16-bit mode: low byte wrap also interrupts if low enable set
// - split mode: each byte reloads from its own reload byte
// - split mode: run bit gates high byte only; low byte always counts
// - byte clock: system_clock if select set, else system_clock/12 or external/8
// - split mode: external select shared, per-byte select may force system_clock
// - external/8 retimed outside suspend, drives counter directly in suspend
// - counting continues in suspend on external clock; overflow wakes device
// - other wake source: sync status high for three external/8 ticks
// - high flag on high byte wrap; low flag on low wrap always
// - split mode: interrupts on high wrap, and low wrap if enabled
// - capture only with capture enable 1 and split 0; system_clock sources outside suspend
// - comparator rising edge copies count into reload, sets high flag
// - control layout fixed; bit 1 reads zero; all bits reset zero
`timescale 1ns/100ps
`include "art_defines.vh"
module art_timer (
   input wire i_clk,
   input wire i_reset,
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_write,
   input wire i_sfr_read,
   input wire [7:0] i_sfr_wdata,
   input wire i_high_byte_system_clock_select,
   input wire i_low_byte_system_clock_select,
   input wire i_timer_irq_enable,
   input wire i_suspend,
   input wire i_external_clock,
   input wire i_comparator,
   output reg [7:0] o_sfr_rdata,
   output reg o_irq_request,
   output reg o_wake,
   output reg o_suspend_sync_status
);
   // control register bits
   reg high_overflow_flag;
   reg low_overflow_flag;
   reg low_byte_irq_enable;
   reg comparator_capture_enable;
   reg split_mode_select;
   reg run_control;
   reg external_clock_select;

   // data registers
   reg [7:0] count_low_byte;
   reg [7:0] count_high_byte;
   reg [7:0] reload_low_byte;
   reg [7:0] reload_high_byte;

   // suspend tracking
   reg suspend_prev;
   reg woke_by_timer;
   reg [1:0] sync_left;

   // next values
   reg [7:0] next_count_low;
   reg [7:0] next_count_high;
   reg [7:0] next_reload_low;
   reg [7:0] next_reload_high;
   reg next_high_flag;
   reg next_low_flag;
   reg high_set;
   reg low_set;

   wire ext_rise;
   wire cmp_rise;
   wire tick_high;
   wire tick_low;
   wire ext_tick;
   wire capture_mode;
   wire access_ok;
   wire wr_control;
   wire wr_reload_low;
   wire wr_reload_high;
   wire wr_count_low;
   wire wr_count_high;
   wire [7:0] control_value;
   wire low_at_top;
   wire high_at_top;

   function hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // registers closed while resynchronising after wake
   assign access_ok = ~o_suspend_sync_status;
   assign wr_control = i_sfr_write & access_ok &
      hit(i_sfr_addr, `ART_ADDR_CONTROL);
   assign wr_reload_low = i_sfr_write & access_ok &
      hit(i_sfr_addr, `ART_ADDR_RELOAD_LOW);
   assign wr_reload_high = i_sfr_write & access_ok &
      hit(i_sfr_addr, `ART_ADDR_RELOAD_HIGH);
   assign wr_count_low = i_sfr_write & access_ok &
      hit(i_sfr_addr, `ART_ADDR_COUNT_LOW);
   assign wr_count_high = i_sfr_write & access_ok &
      hit(i_sfr_addr, `ART_ADDR_COUNT_HIGH);

   assign capture_mode = comparator_capture_enable &
      ~split_mode_select;

   assign low_at_top = (count_low_byte == 8'hff);
   assign high_at_top = (count_high_byte == 8'hff);

   art_edge_sync u_ext_sync (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_pin(i_external_clock),
      .o_rise(ext_rise)
   );

   art_edge_sync u_cmp_sync (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_pin(i_comparator),
      .o_rise(cmp_rise)
   );

   // capture restricts sources to system_clock or system_clock/12 outside suspend; suspend still counts external/8
   art_tick_gen u_tick (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ext_rise(ext_rise),
      .i_suspend(i_suspend),
      .i_ext_sel(external_clock_select & ~capture_mode),
      .i_high_system_clock(i_high_byte_system_clock_select),
      .i_low_system_clock(i_low_byte_system_clock_select),
      .o_tick_high(tick_high),
      .o_tick_low(tick_low),
      .o_ext_tick(ext_tick)
   );

   // counting, reload and capture
   always @* begin
      next_count_low = count_low_byte;
      next_count_high = count_high_byte;
      next_reload_low = reload_low_byte;
      next_reload_high = reload_high_byte;
      high_set = 1'b0;
      low_set = 1'b0;
      if (!split_mode_select) begin
         if (run_control && tick_low) begin
            if (low_at_top && high_at_top) begin
               next_count_low = reload_low_byte;
               next_count_high = reload_high_byte;
               high_set = 1'b1;
               low_set = 1'b1;
            end else if (low_at_top) begin
               next_count_low = 8'h00;
               next_count_high = count_high_byte + 8'h01;
               low_set = 1'b1;
            end else begin
               next_count_low = count_low_byte + 8'h01;
            end
         end
         if (capture_mode && cmp_rise) begin
            next_reload_low = count_low_byte;
            next_reload_high = count_high_byte;
            high_set = 1'b1;
         end
      end else begin
         // low byte ignores the run bit
         if (tick_low) begin
            if (low_at_top) begin
               next_count_low = reload_low_byte;
               low_set = 1'b1;
            end else begin
               next_count_low = count_low_byte + 8'h01;
            end
         end
         if (run_control && tick_high) begin
            if (high_at_top) begin
               next_count_high = reload_high_byte;
               high_set = 1'b1;
            end else begin
               next_count_high = count_high_byte + 8'h01;
            end
         end
      end
      if (wr_count_low) begin
         next_count_low = i_sfr_wdata;
      end
      if (wr_count_high) begin
         next_count_high = i_sfr_wdata;
      end
      if (wr_reload_low && !(capture_mode && cmp_rise)) begin
         next_reload_low = i_sfr_wdata;
      end
      if (wr_reload_high && !(capture_mode && cmp_rise)) begin
         next_reload_high = i_sfr_wdata;
      end
   end

   // flags: only software clears, hardware set wins
   always @* begin
      next_high_flag = high_overflow_flag;
      next_low_flag = low_overflow_flag;
      if (wr_control) begin
         next_high_flag = i_sfr_wdata[`ART_BIT_HIGH_FLAG];
         next_low_flag = i_sfr_wdata[`ART_BIT_LOW_FLAG];
      end
      if (high_set) begin
         next_high_flag = 1'b1;
      end
      if (low_set) begin
         next_low_flag = 1'b1;
      end
   end

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         count_low_byte <= `ART_RESET_BYTE;
         count_high_byte <= `ART_RESET_BYTE;
         reload_low_byte <= `ART_RESET_BYTE;
         reload_high_byte <= `ART_RESET_BYTE;
      end else begin
         count_low_byte <= next_count_low;
         count_high_byte <= next_count_high;
         reload_low_byte <= next_reload_low;
         reload_high_byte <= next_reload_high;
      end
   end

   // control register
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         high_overflow_flag <= 1'b0;
         low_overflow_flag <= 1'b0;
         low_byte_irq_enable <= 1'b0;
         comparator_capture_enable <= 1'b0;
         split_mode_select <= 1'b0;
         run_control <= 1'b0;
         external_clock_select <= 1'b0;
      end else begin
         high_overflow_flag <= next_high_flag;
         low_overflow_flag <= next_low_flag;
         if (wr_control) begin
            low_byte_irq_enable <=
               i_sfr_wdata[`ART_BIT_LOW_IRQ_EN];
            comparator_capture_enable <=
               i_sfr_wdata[`ART_BIT_CAPTURE_EN];
            split_mode_select <= i_sfr_wdata[`ART_BIT_SPLIT];
            run_control <= i_sfr_wdata[`ART_BIT_RUN];
            external_clock_select <=
               i_sfr_wdata[`ART_BIT_EXT_SEL];
         end
      end
   end

   assign control_value = {
      high_overflow_flag,
      low_overflow_flag,
      low_byte_irq_enable,
      comparator_capture_enable,
      split_mode_select,
      run_control,
      1'b0,
      external_clock_select
   };

   // read port
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_read && access_ok) begin
         case (i_sfr_addr)
            `ART_ADDR_CONTROL: begin
               o_sfr_rdata <= control_value;
            end
            `ART_ADDR_RELOAD_LOW: begin
               o_sfr_rdata <= reload_low_byte;
            end
            `ART_ADDR_RELOAD_HIGH: begin
               o_sfr_rdata <= reload_high_byte;
            end
            `ART_ADDR_COUNT_LOW: begin
               o_sfr_rdata <= count_low_byte;
            end
            `ART_ADDR_COUNT_HIGH: begin
               o_sfr_rdata <= count_high_byte;
            end
            default: begin
               o_sfr_rdata <= 8'h00;
            end
         endcase
      end else begin
         o_sfr_rdata <= 8'h00;
      end
   end

   // interrupt request level
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_irq_request <= 1'b0;
      end else begin
         o_irq_request <= i_timer_irq_enable & (next_high_flag |
            (low_byte_irq_enable & next_low_flag));
      end
   end

   // wake on overflow while suspended
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_wake <= 1'b0;
         woke_by_timer <= 1'b0;
      end else begin
         o_wake <= i_suspend & (high_set | low_set) &
            ~(capture_mode & cmp_rise);
         if (!i_suspend) begin
            woke_by_timer <= 1'b0;
         end else if (high_set | low_set) begin
            woke_by_timer <= 1'b1;
         end
      end
   end

   // resync window after a wake from another source
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         suspend_prev <= 1'b0;
         sync_left <= 2'h0;
         o_suspend_sync_status <= 1'b0;
      end else begin
         suspend_prev <= i_suspend;
         if (suspend_prev && !i_suspend && !woke_by_timer) begin
            sync_left <= `ART_SYNC_TICKS;
            o_suspend_sync_status <= 1'b1;
         end else if (sync_left != 2'h0) begin
            if (ext_tick) begin
               sync_left <= sync_left - 2'h1;
               o_suspend_sync_status <= (sync_left != 2'h1);
            end
         end else begin
            o_suspend_sync_status <= 1'b0;
         end
      end
   end
endmodule // art_timer

// ### bench/art_timer_sva.sv
`timescale 1ns/100ps
module art_timer_sva (
   input wire i_clk,
   input wire i_reset,
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_write,
   input wire i_sfr_read,
   input wire [7:0] i_sfr_wdata,
   input wire i_high_byte_system_clock_select,
   input wire i_low_byte_system_clock_select,
   input wire i_timer_irq_enable,
   input wire i_suspend,
   input wire i_external_clock,
   input wire i_comparator,
   input wire [7:0] o_sfr_rdata,
   input wire o_irq_request,
   input wire o_wake,
   input wire o_suspend_sync_status
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   AST_RD_IDLE: assert property (
      !$past(i_sfr_read) |-> o_sfr_rdata == 8'h00)
      else $error("read data not idle");
   AST_CTRL_BIT1: assert property (
      $past(i_sfr_read) && $past(i_sfr_addr) == 8'h91 |-> !o_sfr_rdata[1])
      else $error("unused control bit reads one");
   AST_UNMAPPED: assert property (
      $past(i_sfr_read) && ($past(i_sfr_addr) < 8'h91 ||
      $past(i_sfr_addr) > 8'h95) |-> o_sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_IRQ_NOEN: assert property (
      !$past(i_timer_irq_enable) |-> !o_irq_request)
      else $error("irq without enable");
   AST_IRQ_STICKY: assert property (
      o_irq_request && i_timer_irq_enable && !i_sfr_write |=> o_irq_request)
      else $error("irq dropped without software clear");
   AST_WAKE: assert property (
      o_wake |-> $past(i_suspend) ##1 !o_wake)
      else $error("wake outside suspend or too long");
   AST_SYNC_RISE: assert property (
      $rose(o_suspend_sync_status) |-> $past(i_suspend) ||
      $past(i_suspend, 2) || $past(i_suspend, 3))
      else $error("sync status without suspend exit");
   AST_SYNC_BLOCK: assert property (
      o_suspend_sync_status && i_sfr_read |=> o_sfr_rdata == 8'h00)
      else $error("read served during resync");
endmodule // art_timer_sva
bind art_timer art_timer_sva art_timer_sva_i (.i_clk(i_clk),
   .i_reset(i_reset), .i_sfr_addr(i_sfr_addr), .i_sfr_write(i_sfr_write),
   .i_sfr_read(i_sfr_read), .i_sfr_wdata(i_sfr_wdata),
   .i_high_byte_system_clock_select(i_high_byte_system_clock_select),
   .i_low_byte_system_clock_select(i_low_byte_system_clock_select),
   .i_timer_irq_enable(i_timer_irq_enable), .i_suspend(i_suspend),
   .i_external_clock(i_external_clock), .i_comparator(i_comparator),
   .o_sfr_rdata(o_sfr_rdata), .o_irq_request(o_irq_request),
   .o_wake(o_wake), .o_suspend_sync_status(o_suspend_sync_status));

// ### bench/art_timer_tb.sv
`timescale 1ns/100ps
module art_timer_tb;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] addr = 8'h00;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg hsel = 1'b1;
   reg lsel = 1'b1;
   reg ien = 1'b0;
   reg susp = 1'b0;
   reg ext = 1'b0;
   reg cmp = 1'b0;
   reg seen = 1'b0;
   wire [7:0] rdata;
   wire irq;
   wire wake;
   wire sync;
   integer miscompares = 0;
   integer cmp_count = 0;
   integer n;
   always #5 clk = ~clk;
   always @(posedge clk) if (wake === 1'b1) seen <= 1'b1;
   art_timer art_timer_i (.i_clk(clk), .i_reset(reset), .i_sfr_addr(addr),
      .i_sfr_write(wr), .i_sfr_read(rd), .i_sfr_wdata(wdata),
      .i_high_byte_system_clock_select(hsel), .i_low_byte_system_clock_select(lsel),
      .i_timer_irq_enable(ien), .i_suspend(susp), .i_external_clock(ext),
      .i_comparator(cmp), .o_sfr_rdata(rdata), .o_irq_request(irq),
      .o_wake(wake), .o_suspend_sync_status(sync));
   task end_of_test;
      begin
         $display("compares %0d mismatches %0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer c);
      repeat (c) @(posedge clk);
   endtask
   task wrr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rdc(input [7:0] a, input [7:0] m, input [7:0] e);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         chk(rdata & m, e);
      end
   endtask
   task extk(input integer c);
      repeat (c) begin
         cyc(2);
         ext <= 1'b1;
         cyc(2);
         ext <= 1'b0;
      end
   endtask
   initial begin
      #100000;
      miscompares = miscompares + 1;
      end_of_test;
   end
   initial begin
      cyc(3);
      reset <= 1'b0;
      for (n = 8'h91; n <= 8'h96; n = n + 1) rdc(n[7:0], 8'hff, 8'h00);
      wrr(8'h91, 8'hff);
      rdc(8'h91, 8'hff, 8'hfd);
      wrr(8'h91, 8'h00);
      wrr(8'h93, 8'hff);
      wrr(8'h92, 8'hf0);
      wrr(8'h95, 8'hff);
      wrr(8'h94, 8'hfe);
      wrr(8'h91, 8'h04);
      cyc(4);
      rdc(8'h91, 8'hff, 8'hc4);
      rdc(8'h95, 8'hff, 8'hff);
      chk({7'h00, irq}, 8'h00);
      cyc(1);
      ien <= 1'b1;
      cyc(2);
      #1;
      chk({7'h00, irq}, 8'h01);
      wrr(8'h91, 8'h00);
      wrr(8'h91, 8'h00);
      rdc(8'h91, 8'hff, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wrr(8'h95, 8'h00);
      wrr(8'h94, 8'hfe);
      wrr(8'h91, 8'h24);
      cyc(4);
      rdc(8'h91, 8'hff, 8'h64);
      chk({7'h00, irq}, 8'h01);
      rdc(8'h95, 8'hff, 8'h01);
      wrr(8'h91, 8'h00);
      wrr(8'h91, 8'h00);
      wrr(8'h92, 8'hf0);
      wrr(8'h94, 8'hf0);
      wrr(8'h95, 8'h20);
      wrr(8'h91, 8'h08);
      cyc(40);
      rdc(8'h91, 8'hff, 8'h48);
      rdc(8'h95, 8'hff, 8'h20);
      rdc(8'h94, 8'hf0, 8'hf0);
      cyc(1);
      hsel <= 1'b0;
      wrr(8'h93, 8'h80);
      wrr(8'h95, 8'hff);
      wrr(8'h91, 8'h0c);
      cyc(30);
      rdc(8'h95, 8'hfc, 8'h80);
      rdc(8'h91, 8'hbf, 8'h8c);
      chk({7'h00, irq}, 8'h01);
      wrr(8'h91, 8'h00);
      wrr(8'h91, 8'h00);
      wrr(8'h95, 8'h12);
      wrr(8'h94, 8'h34);
      wrr(8'h91, 8'h10);
      cyc(1);
      cmp <= 1'b1;
      cyc(6);
      cmp <= 1'b0;
      cyc(2);
      rdc(8'h93, 8'hff, 8'h12);
      rdc(8'h92, 8'hff, 8'h34);
      rdc(8'h91, 8'hff, 8'h90);
      wrr(8'h91, 8'h18);
      wrr(8'h95, 8'h56);
      cmp <= 1'b1;
      cyc(6);
      cmp <= 1'b0;
      cyc(2);
      rdc(8'h93, 8'hff, 8'h12);
      rdc(8'h91, 8'hff, 8'h18);
      cyc(1);
      lsel <= 1'b0;
      wrr(8'h91, 8'h00);
      wrr(8'h95, 8'hff);
      wrr(8'h94, 8'hff);
      wrr(8'h91, 8'h05);
      cyc(1);
      susp <= 1'b1;
      extk(12);
      chk({7'h00, seen}, 8'h01);
      susp <= 1'b0;
      extk(32);
      rdc(8'h91, 8'h80, 8'h80);
      cyc(1);
      susp <= 1'b1;
      cyc(4);
      susp <= 1'b0;
      cyc(2);
      #1;
      chk({7'h00, sync}, 8'h01);
      rdc(8'h91, 8'hff, 8'h00);
      extk(32);
      #1;
      chk({7'h00, sync}, 8'h00);
      wrr(8'h91, 8'h00);
      hsel <= 1'b1;
      wrr(8'h94, 8'h00);
      wrr(8'h95, 8'h00);
      wrr(8'h91, 8'h0d);
      extk(16);
      rdc(8'h94, 8'hff, 8'h02);
      rdc(8'h95, 8'hf0, 8'h40);
      end_of_test;
   end
endmodule // art_timer_tb
